/* src/dme_pkg.sv */
// Package for the debug mode entry select block
`default_nettype none
package dme_pkg;
    localparam int DME_BIT_CYCLES = 16;
    localparam int DME_SAMPLE_CYCLE = 10;
    localparam int DME_TIMEOUT_CYCLES = 512;
    localparam int DME_CNT_W = 10;
    localparam logic [7:0] DME_CMD_BACKGROUND = 8'h90;
    localparam logic [7:0] DME_CMD_FORCE_RESET = 8'hC4;
    localparam logic [7:0] DME_CMD_SET_BKPT = 8'hC2;
    localparam logic [7:0] DME_CMD_ENABLE = 8'hC8;
    localparam logic [7:0] DME_CMD_GO = 8'h08;
    localparam logic [2:0] DME_SYNC_RESET = 3'h7;

    typedef enum logic [1:0] {
        DME_RST_POWER_ON = 2'b00,
        DME_RST_PIN = 2'b01,
        DME_RST_ERROR = 2'b10,
        DME_RST_DEBUG = 2'b11
    } dme_cause_type;

    typedef enum logic [1:0] {
        DME_RX_IDLE = 2'b00,
        DME_RX_WAIT = 2'b01,
        DME_RX_DONE = 2'b10
    } dme_rx_state_type;

    typedef struct packed {
        logic watchdog_disable;
        logic osc_keep_running;
        logic cpu_wake;
        logic bkpt_hit;
    } dme_ctl_type;
endpackage
`default_nettype wire

/* src/dme_top.sv */
// Debug mode entry select with single-wire receiver and breakpoint
`default_nettype none
module dme_top
    import dme_pkg::*;
#(
    parameter int ADDR_W = 16
)(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic reset_exit,
    input wire dme_cause_type reset_cause,
    input wire logic debug_wire_pin_in,
    output logic debug_wire_pin_out,
    output logic debug_wire_pin_oe,
    output logic debug_wire_pullup_en,
    input wire logic cpu_in_stop,
    input wire logic cpu_in_wait,
    input wire logic cpu_exec_go,
    input wire logic [ADDR_W-1:0] cpu_fetch_addr,
    input wire logic cpu_fetch_valid,
    output logic background_mode,
    output dme_ctl_type ctl
);
    logic [2:0] pin_sync;
    logic [2:0] next_pin_sync;
    logic pin_level;
    logic next_pin_level;
    dme_rx_state_type rx_state;
    dme_rx_state_type next_rx_state;
    logic [DME_CNT_W-1:0] bit_cnt;
    logic [DME_CNT_W-1:0] next_bit_cnt;
    logic [DME_CNT_W-1:0] idle_cnt;
    logic [DME_CNT_W-1:0] next_idle_cnt;
    logic [4:0] shift_cnt;
    logic [4:0] next_shift_cnt;
    logic [23:0] shreg;
    logic [23:0] next_shreg;
    logic [7:0] cmd;
    logic [7:0] next_cmd;
    logic force_debug_reset_bit;
    logic next_force_debug_reset_bit;
    logic bdc_enable;
    logic next_bdc_enable;
    logic bkpt_en;
    logic next_bkpt_en;
    logic [ADDR_W-1:0] bkpt_addr;
    logic [ADDR_W-1:0] next_bkpt_addr;
    logic bg_mode;
    logic next_bg_mode;
    logic wake;
    logic next_wake;
    logic hit;
    logic next_hit;
    logic fall;
    logic force_wr;

    // Pin is only an input here; driver released, pullup on
    assign debug_wire_pin_out = 1'b1;
    assign debug_wire_pin_oe = 1'b1;
    assign debug_wire_pullup_en = 1'b1;

    // Three-stage synchroniser, change accepted when stages two and three agree
    always_comb
    begin
        next_pin_sync = {pin_sync[1:0], debug_wire_pin_in};
        next_pin_level = pin_level;
        if (pin_sync[1] == pin_sync[2])
        begin
            next_pin_level = pin_sync[2];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_sync <= DME_SYNC_RESET;
            pin_level <= 1'b1;
        end
        else
        begin
            pin_sync <= next_pin_sync;
            pin_level <= next_pin_level;
        end
    end

    assign fall = pin_level && (pin_sync[1] == pin_sync[2]) && !pin_sync[2];

    // Serial receiver: one bit per host falling edge, sampled at cycle 10
    always_comb
    begin
        next_rx_state = rx_state;
        next_bit_cnt = bit_cnt;
        next_idle_cnt = idle_cnt;
        next_shift_cnt = shift_cnt;
        next_shreg = shreg;
        next_cmd = cmd;
        next_force_debug_reset_bit = force_debug_reset_bit;
        next_bdc_enable = bdc_enable;
        next_bkpt_en = bkpt_en;
        next_bkpt_addr = bkpt_addr;
        next_bg_mode = bg_mode;
        next_wake = 1'b0;
        next_hit = 1'b0;
        force_wr = 1'b0;
        if (fall)
        begin
            next_idle_cnt = '0;
        end
        else if (shift_cnt != 5'h00 || rx_state != DME_RX_IDLE)
        begin
            next_idle_cnt = idle_cnt + 1'b1;
        end
        case (rx_state)
            DME_RX_IDLE:
            begin
                if (fall)
                begin
                    next_rx_state = DME_RX_WAIT;
                    next_bit_cnt = '0;
                end
            end
            DME_RX_WAIT:
            begin
                next_bit_cnt = bit_cnt + 1'b1;
                if (bit_cnt == DME_CNT_W'(DME_SAMPLE_CYCLE - 1))
                begin
                    next_shreg = {shreg[22:0], pin_level};
                    next_shift_cnt = shift_cnt + 1'b1;
                    next_rx_state = DME_RX_DONE;
                end
            end
            DME_RX_DONE:
            begin
                next_rx_state = DME_RX_IDLE;
                if (shift_cnt == 5'h08)
                begin
                    next_cmd = shreg[7:0];
                    if (shreg[7:0] == DME_CMD_BACKGROUND)
                    begin
                        next_bg_mode = 1'b1;
                        next_wake = cpu_in_stop || cpu_in_wait;
                        next_shift_cnt = '0;
                    end
                    else if (shreg[7:0] == DME_CMD_GO)
                    begin
                        next_bg_mode = 1'b0;
                        next_shift_cnt = '0;
                    end
                end
                else if (shift_cnt == 5'h10 && cmd == DME_CMD_FORCE_RESET)
                begin
                    force_wr = 1'b1;
                    next_force_debug_reset_bit = shreg[0];
                    next_shift_cnt = '0;
                end
                else if (shift_cnt == 5'h10 && cmd == DME_CMD_ENABLE)
                begin
                    next_bdc_enable = shreg[0];
                    next_bkpt_en = shreg[1];
                    next_shift_cnt = '0;
                end
                else if (shift_cnt == 5'h18 && cmd == DME_CMD_SET_BKPT)
                begin
                    next_bkpt_addr = ADDR_W'(shreg[15:0]);
                    next_shift_cnt = '0;
                end
                else if (shift_cnt == 5'h18)
                begin
                    next_shift_cnt = '0;
                end
            end
            default:
            begin
                next_rx_state = DME_RX_IDLE;
            end
        endcase
        if (idle_cnt == DME_CNT_W'(DME_TIMEOUT_CYCLES - 1))
        begin
            next_rx_state = DME_RX_IDLE;
            next_shift_cnt = '0;
            next_idle_cnt = '0;
            next_shreg = '0;
        end
        if (cpu_exec_go)
        begin
            next_bg_mode = 1'b0;
        end
        if (bkpt_en && cpu_fetch_valid && cpu_fetch_addr == bkpt_addr && !bg_mode)
        begin
            next_hit = 1'b1;
            next_bg_mode = 1'b1;
        end
        if (reset_exit)
        begin
            // A command write in the same cycle wins over the clear
            if (!force_wr)
            begin
                next_force_debug_reset_bit = 1'b0;
            end
            case (reset_cause)
                DME_RST_POWER_ON: next_bg_mode = !pin_level;
                DME_RST_DEBUG: next_bg_mode = force_debug_reset_bit && !pin_level;
                DME_RST_PIN: next_bg_mode = 1'b0;
                DME_RST_ERROR: next_bg_mode = 1'b0;
                default: next_bg_mode = 1'b0;
            endcase
        end
    end

    // Debug state lives only here, never on the CPU bus
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_state <= DME_RX_IDLE;
            bit_cnt <= '0;
            idle_cnt <= '0;
            shift_cnt <= '0;
            shreg <= '0;
            cmd <= 8'h00;
            force_debug_reset_bit <= 1'b0;
            bdc_enable <= 1'b0;
            bkpt_en <= 1'b0;
            bkpt_addr <= '0;
            bg_mode <= 1'b0;
            wake <= 1'b0;
            hit <= 1'b0;
        end
        else
        begin
            rx_state <= next_rx_state;
            bit_cnt <= next_bit_cnt;
            idle_cnt <= next_idle_cnt;
            shift_cnt <= next_shift_cnt;
            shreg <= next_shreg;
            cmd <= next_cmd;
            force_debug_reset_bit <= next_force_debug_reset_bit;
            bdc_enable <= next_bdc_enable;
            bkpt_en <= next_bkpt_en;
            bkpt_addr <= next_bkpt_addr;
            bg_mode <= next_bg_mode;
            wake <= next_wake;
            hit <= next_hit;
        end
    end

    assign background_mode = bg_mode;
    assign ctl.watchdog_disable = bg_mode;
    assign ctl.osc_keep_running = bdc_enable;
    assign ctl.cpu_wake = wake;
    assign ctl.bkpt_hit = hit;
endmodule
`default_nettype wire

/* sim/dme_pod.sv */
// Debug pod model driving the single-wire pin
`default_nettype none
module dme_pod (
    input wire logic ref_clk,
    output logic pull_low
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pull_low = 1'b0;
    task automatic hold(input logic l);
        pull_low = l;
    endtask
    task automatic wait_edges(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Bits sent MSB first, each opened by a falling edge
    task automatic send_bits(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            pull_low = 1'b1;
            wait_edges(v[i] ? 4 : 16);
            pull_low = 1'b0;
            wait_edges(v[i] ? 18 : 6);
        end
    endtask
endmodule
`default_nettype wire

/* sim/dme_top_sva.sv */
// Assertions for the debug mode entry select block
`default_nettype none
module dme_top_sva
    import dme_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic reset_exit,
    input wire dme_cause_type reset_cause,
    input wire logic debug_wire_pin_in,
    input wire logic debug_wire_pin_oe,
    input wire logic debug_wire_pullup_en,
    input wire logic background_mode,
    input wire dme_ctl_type ctl
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    AST_USER_CAUSE: assert property (
        reset_exit && reset_cause inside {DME_RST_PIN, DME_RST_ERROR} |=> !background_mode)
        else $error("user cause gave background");
    AST_PIN_HIGH: assert property (
        debug_wire_pin_in [*5] ##0 reset_exit |=> !background_mode)
        else $error("high pin gave background");
    AST_POWER_ON_LOW: assert property (
        !debug_wire_pin_in [*5] ##0 (reset_exit && reset_cause == DME_RST_POWER_ON)
        |=> background_mode)
        else $error("low pin at power-on gave user mode");
    AST_WDOG: assert property (ctl.watchdog_disable == background_mode)
        else $error("watchdog not tied to background");
    AST_PULLUP: assert property (debug_wire_pullup_en && debug_wire_pin_oe)
        else $error("pin not left to pullup");
    AST_WAKE_BG: assert property (ctl.cpu_wake |-> ##[0:3] background_mode)
        else $error("wake without background");
    AST_WAKE_PULSE: assert property (ctl.cpu_wake |=> !ctl.cpu_wake)
        else $error("wake longer than a cycle");
    AST_BKPT_BG: assert property (
        ctl.bkpt_hit |-> background_mode && !$past(background_mode))
        else $error("breakpoint entry wrong");
    AST_BKPT_PULSE: assert property (ctl.bkpt_hit |=> !ctl.bkpt_hit)
        else $error("breakpoint longer than a cycle");
    cover property (reset_exit ##1 background_mode);
    cover property (ctl.cpu_wake);
    cover property (ctl.bkpt_hit);
endmodule
bind dme_top dme_top_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n), .reset_exit(reset_exit),
    .reset_cause(reset_cause), .debug_wire_pin_in(debug_wire_pin_in),
    .debug_wire_pin_oe(debug_wire_pin_oe), .debug_wire_pullup_en(debug_wire_pullup_en),
    .background_mode(background_mode), .ctl(ctl));
`default_nettype wire

/* sim/tb_top.sv */
// Testbench for the debug mode entry select block
`default_nettype none
module tb_top;
    import dme_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, rst_n, reset_exit, pin_in, pin_out, pin_oe, pull_low, background_mode;
    logic cpu_in_stop, cpu_in_wait, cpu_exec_go, cpu_fetch_valid;
    logic [15:0] cpu_fetch_addr;
    dme_cause_type reset_cause;
    dme_ctl_type ctl;
    int err_count = 0;
    int comparisons = 0;
    int wake_seen = 0;
    int hit_seen = 0;
    // Pin idles high through the pullup
    assign pin_in = (pull_low || (!pin_oe && !pin_out)) ? 1'b0 : 1'b1;
    dme_pod pod (.ref_clk(ref_clk), .pull_low(pull_low));
    dme_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reset_exit(reset_exit),
        .reset_cause(reset_cause), .debug_wire_pin_in(pin_in), .debug_wire_pin_out(pin_out),
        .debug_wire_pin_oe(pin_oe), .debug_wire_pullup_en(), .cpu_in_stop(cpu_in_stop),
        .cpu_in_wait(cpu_in_wait), .cpu_exec_go(cpu_exec_go), .cpu_fetch_addr(cpu_fetch_addr),
        .cpu_fetch_valid(cpu_fetch_valid), .background_mode(background_mode), .ctl(ctl));
    always @(posedge ref_clk)
    begin
        wake_seen += (ctl.cpu_wake === 1'b1);
        hit_seen += (ctl.bkpt_hit === 1'b1);
    end
    task automatic chk(input string name, input logic seen, input logic exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %b seen %b", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [15:0] arg, input int n);
        pod.send_bits({8'h00, op}, 8);
        if (n > 0)
            pod.send_bits(arg, n);
        cyc(4);
    endtask
    task automatic test_causes();
        for (int c = 0; c < 4; c++)
            for (int p = 1; p >= 0; p--)
            begin
                if (c == 3)
                begin
                    // Held pin leaves a stray bit; let it time out first
                    cyc(DME_TIMEOUT_CYCLES + 8);
                    cmd(DME_CMD_FORCE_RESET, 16'h0001, 8);
                end
                pod.hold(p[0]);
                cyc(6);
                reset_cause = dme_cause_type'(c);
                reset_exit = 1'b1;
                cyc(1);
                reset_exit = 1'b0;
                cyc(1);
                pod.hold(1'b0);
                chk("background_mode", background_mode, p == 1 && c % 3 == 0);
                cyc(2);
            end
    endtask
    task automatic test_wake();
        int n;
        for (int i = 0; i < 2; i++)
        begin
            cpu_in_stop = (i == 0);
            cpu_in_wait = (i == 1);
            n = wake_seen;
            cmd(DME_CMD_BACKGROUND, 16'h0000, 0);
            chk("cpu_wake", wake_seen == n + 1, 1'b1);
            chk("watchdog_disable", ctl.watchdog_disable, 1'b1);
            cpu_exec_go = 1'b1;
            cyc(1);
            cpu_exec_go = 1'b0;
            cyc(2);
            chk("watchdog_disable", ctl.watchdog_disable, 1'b0);
        end
    endtask
    task automatic test_bkpt();
        int n;
        cmd(DME_CMD_ENABLE, 16'h0003, 8);
        chk("osc_keep_running", ctl.osc_keep_running, 1'b1);
        cmd(DME_CMD_SET_BKPT, 16'h1234, 16);
        cpu_in_wait = 1'b0;
        n = hit_seen;
        cpu_fetch_valid = 1'b1;
        cpu_fetch_addr = 16'h1235;
        cyc(2);
        chk("bkpt_miss", hit_seen == n, 1'b1);
        cpu_fetch_addr = 16'h1234;
        cyc(2);
        cpu_fetch_valid = 1'b0;
        chk("bkpt_hit", hit_seen == n + 1, 1'b1);
        cmd(DME_CMD_GO, 16'h0000, 0);
        chk("background_mode", background_mode, 1'b0);
    endtask
    task automatic test_timeout();
        pod.send_bits(16'h000C, 4);
        cyc(600);
        cmd(DME_CMD_BACKGROUND, 16'h0000, 0);
        chk("background_mode", background_mode, 1'b1);
    endtask
    task automatic finish_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        rst_n = 1'b0;
        reset_exit = 1'b0;
        reset_cause = DME_RST_POWER_ON;
        cpu_in_stop = 1'b0;
        cpu_in_wait = 1'b0;
        cpu_exec_go = 1'b0;
        cpu_fetch_valid = 1'b0;
        cpu_fetch_addr = 16'h0000;
        cyc(3);
        rst_n = 1'b1;
        cyc(5);
        test_causes();
        test_wake();
        test_bkpt();
        test_timeout();
        finish_test();
    end
    initial
    begin
        #500000;
        err_count++;
        finish_test();
    end
endmodule
`default_nettype wire
